// ### pts_pkg.sv
// Purpose: constants for the pcm transmit slot port
// Assumes: 50 MHz system clock
// Notes: no software registers
package pts_pkg;
  localparam int SLOT_BITS = 8;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [6:0] SLOT_RST = 7'h00;
  localparam logic [9:0] BCNT_RST = 10'h000;
  localparam logic [1:0] SYNC_RST = 2'h0;
  typedef enum logic [2:0] {
    PTS_IDLE = 3'b001,
    PTS_WAIT = 3'b010,
    PTS_SEND = 3'b100
  } pts_state_t;
endpackage : pts_pkg

// ### pts_sync.sv
// Purpose: two flip-flop synchroniser for pin inputs
// Assumes: async active-low reset
// Notes: first stage read only by second stage
`timescale 1ns/1ps
module pts_sync #(
  parameter int W = 1
) (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_reg;
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_reg <= '0;
      q_o <= '0;
    end else begin
      meta_reg <= d_i;
      q_o <= meta_reg;
    end
  end
endmodule : pts_sync

// ### pts_tx_port.sv
// Operation
// - 8 kHz sync; non-delayed marks own slot
// - delayed mode: counter locates assigned slot
// - data output floats outside its slot
// - data bits change on rising bit clock
// - companded byte on selected port only
// - slot flag floats outside active slot
// - slot flag pulled low during slot
//
// Purpose: transmit slot engine of a serial pcm port
// Assumes: bit clock and frame sync sampled by clk_sys_i, bit clock at most 4.096 MHz
// Notes: sample_i is already companded; sample is captured at the frame sync leading edge
//        sync edges during a wait or a slot are ignored, one slot per sync
`timescale 1ns/1ps
module pts_tx_port (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic bit_clk_i,
  input wire logic tx_frame_sync_i,
  input wire logic delayed_mode_i,
  input wire logic [6:0] slot_num_i,
  input wire logic port_sel_i,
  input wire logic [7:0] sample_i,
  output logic tx_data_port_a_o,
  output logic tx_data_port_a_oe_o,
  output logic tx_data_port_b_o,
  output logic tx_data_port_b_oe_o,
  output logic tx_slot_flag_a_o,
  output logic tx_slot_flag_a_oe_o,
  output logic tx_slot_flag_b_o,
  output logic tx_slot_flag_b_oe_o
);
  import pts_pkg::*;

  // ****************************************
  // reset and input synchronisers
  // ****************************************
  logic [1:0] rst_reg;
  logic rst_n;
  logic bclk_s;
  logic fs_s;

  // release is delayed two clocks so no flop leaves reset close to an edge
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_reg <= SYNC_RST;
    end else begin
      rst_reg <= {rst_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_reg[1];

  pts_sync #(.W(2)) u_sync (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rst_n),
    .d_i({bit_clk_i, tx_frame_sync_i}),
    .q_o({bclk_s, fs_s})
  );

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    pts_state_t st;
    logic bclk_d;
    logic fs_d;
    logic [6:0] slot_cnt;
    logic [2:0] bit_cnt;
    logic [7:0] shift;
    logic port;
    logic dout;
    logic act;
    logic [3:0] bits;
  } pts_regs_t;

  pts_regs_t s_reg;
  pts_regs_t s_next;
  logic rise;
  logic fall;

  // frame sync sampled on falling bit clock so it is stable before the rising edge
  assign rise = bclk_s & ~s_reg.bclk_d;
  assign fall = ~bclk_s & s_reg.bclk_d;

  always_comb begin
    s_next = s_reg;
    s_next.bclk_d = bclk_s;
    if (fall) begin
      s_next.fs_d = fs_s;
    end
    case (s_reg.st)
      PTS_IDLE: begin
        // leading edge of frame sync, seen at a falling bit clock
        if (fall && fs_s && !s_reg.fs_d) begin
          s_next.port = port_sel_i;
          s_next.shift = sample_i;
          s_next.bit_cnt = 3'h0;
          if (delayed_mode_i && slot_num_i != SLOT_RST) begin
            s_next.slot_cnt = slot_num_i;
            s_next.st = PTS_WAIT;
          end else begin
            s_next.st = PTS_SEND;
          end
        end
      end
      PTS_WAIT: begin
        // count whole slots of eight bit clocks
        if (rise) begin
          s_next.bit_cnt = s_reg.bit_cnt + 3'h1;
          if (s_reg.bit_cnt == BIT_LAST) begin
            s_next.slot_cnt = s_reg.slot_cnt - 7'h01;
            if (s_reg.slot_cnt == 7'h01) begin
              s_next.st = PTS_SEND;
            end
          end
        end
      end
      PTS_SEND: begin
        if (rise) begin
          s_next.dout = s_reg.shift[SLOT_BITS-1];
          s_next.shift = {s_reg.shift[6:0], 1'b0};
          s_next.bit_cnt = s_reg.bit_cnt + 3'h1;
        end
        // slot ends at the first rising edge after the eighth bit; the sync level is
        // not looked at, so a square-wave sync still high here cannot hold the slot open
        if (rise && s_reg.bit_cnt == 3'h0 && s_reg.act) begin
          s_next.st = PTS_IDLE;
        end
      end
      default: begin
        s_next.st = PTS_IDLE;
      end
    endcase

    // drive window: from the first rising edge of the slot for eight bit periods
    if (s_reg.st == PTS_SEND && rise) begin
      if (!s_reg.act && s_reg.bits == 4'h0) begin
        s_next.act = 1'b1;
        s_next.bits = 4'h1;
      end else if (s_reg.bits == 4'h8) begin
        s_next.act = 1'b0;
        s_next.bits = 4'h0;
      end else begin
        s_next.bits = s_reg.bits + 4'h1;
      end
    end
    // outside the send state the window is always shut
    if (s_reg.st != PTS_SEND) begin
      s_next.act = 1'b0;
      s_next.bits = 4'h0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '{st: PTS_IDLE, bclk_d: 1'b0, fs_d: 1'b0, slot_cnt: SLOT_RST,
                 bit_cnt: 3'h0, shift: 8'h00, port: 1'b0, dout: 1'b0,
                 act: 1'b0, bits: 4'h0};
    end else begin
      s_reg <= s_next;
    end
  end

  // ****************************************
  // pins
  // ****************************************
  // both data pins carry the same bit; only the enables tell which one is live
  assign tx_data_port_a_o = s_reg.dout;
  assign tx_data_port_b_o = s_reg.dout;
  assign tx_data_port_a_oe_o = s_reg.act & ~s_reg.port;
  assign tx_data_port_b_oe_o = s_reg.act & s_reg.port;
  assign tx_slot_flag_a_o = 1'b0;
  assign tx_slot_flag_b_o = 1'b0;
  assign tx_slot_flag_a_oe_o = s_reg.act & ~s_reg.port;
  assign tx_slot_flag_b_oe_o = s_reg.act & s_reg.port;

  // ****************************************
  // checks
  // ****************************************
  a_data_float_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    tx_data_port_a_oe_o |-> s_reg.st == PTS_SEND)
    else $error("port a driven outside slot");
  a_flag_match_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    tx_slot_flag_a_oe_o == tx_data_port_a_oe_o)
    else $error("flag a not aligned with data a");
  a_flag_low: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    tx_slot_flag_b_oe_o |-> !tx_slot_flag_b_o)
    else $error("flag b not pulled low");
  a_one_port: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    !(tx_data_port_a_oe_o && tx_data_port_b_oe_o))
    else $error("both ports driven");
  a_bit_on_rise: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    $changed(s_reg.dout) |-> $past(rise))
    else $error("data changed off rising edge");
  a_slot_len: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    s_reg.bits <= 4'h8)
    else $error("slot longer than eight bits");
  a_wait_go: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    (s_reg.st == PTS_WAIT && s_next.st == PTS_SEND) |-> s_reg.slot_cnt == 7'h01)
    else $error("wait left early");
  a_nondelay: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    (s_reg.st == PTS_IDLE && s_next.st != PTS_IDLE && !delayed_mode_i) |=>
      s_reg.st == PTS_SEND)
    else $error("non-delayed sync did not start slot");
  a_data_float_b: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    tx_data_port_b_oe_o |-> s_reg.st == PTS_SEND)
    else $error("port b driven outside slot");
  a_flag_match_b: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    tx_slot_flag_b_oe_o == tx_data_port_b_oe_o)
    else $error("flag b not aligned with data b");
  a_flag_low_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    tx_slot_flag_a_oe_o |-> !tx_slot_flag_a_o)
    else $error("flag a not pulled low");
  a_slot_close: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    $fell(s_reg.act) |-> s_reg.st == PTS_IDLE)
    else $error("slot left open after eighth bit");
  a_port_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    s_reg.act |-> $stable(s_reg.port))
    else $error("port changed inside slot");
endmodule : pts_tx_port

// ### pts_bus_model.sv
// Purpose: far-side pcm backplane model
// Assumes: bit clock 160 ns, eight system clocks
// Notes: bit clock runs free, as a backplane clock does
`timescale 1ns/1ps
module pts_bus_model (
  output logic bit_clk_o,
  output logic tx_frame_sync_o
);
  // ****
  // clock and sync
  // ****
  int sync_hold = 0;
  // the bit clock also stands in for the master clock; it runs fast to keep runs short
  initial begin
    bit_clk_o = 1'b0;
    tx_frame_sync_o = 1'b0;
    forever #80 bit_clk_o = ~bit_clk_o;
  end
  // sync high for w bit clocks, launched on a rising edge; returns one bit clock later
  task automatic send_sync(input int w);
    @(posedge bit_clk_o);
    tx_frame_sync_o <= 1'b1;
    sync_hold <= w;
    @(posedge bit_clk_o);
  endtask : send_sync
  // lowers the sync once its width has run out, so a long sync outlives the task
  always @(posedge bit_clk_o) begin
    if (sync_hold > 0) begin
      sync_hold <= sync_hold - 1;
      if (sync_hold == 1) begin
        tx_frame_sync_o <= 1'b0;
      end
    end
  end
endmodule : pts_bus_model

// ### pts_tx_port_tb.sv
// Purpose: self-checking bench for the transmit slot port
// Assumes: bits sampled at the next rising bit clock
// Notes: open-drain flags see a pull-up here
`timescale 1ns/1ps
module pts_tx_port_tb;
  logic clk_sys_i, rstn_i, bclk, fs, dmode, psel;
  logic [6:0] slot;
  logic [7:0] smp;
  logic da, da_oe, db, db_oe, fa, fa_oe, fb, fb_oe;
  int error_cnt = 0;
  int tests_run = 0;
  wire fa_w = fa_oe ? fa : 1'b1;
  wire fb_w = fb_oe ? fb : 1'b1;
  pts_bus_model i_pts_bus_model (.bit_clk_o(bclk), .tx_frame_sync_o(fs));
  pts_tx_port i_pts_tx_port (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .bit_clk_i(bclk),
    .tx_frame_sync_i(fs), .delayed_mode_i(dmode), .slot_num_i(slot), .port_sel_i(psel),
    .sample_i(smp), .tx_data_port_a_o(da), .tx_data_port_a_oe_o(da_oe),
    .tx_data_port_b_o(db), .tx_data_port_b_oe_o(db_oe), .tx_slot_flag_a_o(fa),
    .tx_slot_flag_a_oe_o(fa_oe), .tx_slot_flag_b_o(fb), .tx_slot_flag_b_oe_o(fb_oe));
  // ****
  // shared tasks
  // ****
  task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic frame(input logic d, input logic [6:0] s, input logic p, input logic [7:0] v,
                       input int w);
    logic [7:0] got, fl, ot;
    int n;
    @(negedge clk_sys_i);
    dmode = d;
    slot = s;
    psel = p;
    smp = v;
    i_pts_bus_model.send_sync(w);
    n = 0;
    do begin
      @(posedge bclk);
      n++;
    end while ((p ? db_oe : da_oe) !== 1'b1 && n < 1100);
    chk("slot start", d ? 10'(8 * s + 1) : 10'h1, 10'(n));
    // sample just before the next rise, away from the update
    for (int i = 7; i >= 0; i--) begin
      got[i] = p ? db : da;
      fl[i] = p ? fb_w : fa_w;
      ot[i] = p ? (da_oe | fa_oe) : (db_oe | fb_oe);
      @(posedge bclk);
    end
    chk("data", {2'h0, v}, {2'h0, got});
    chk("flag low", 10'h0, {2'h0, fl});
    chk("other port", 10'h0, {2'h0, ot});
    chk("released", 10'h0, {8'h0, p ? db_oe : da_oe, p ? ~fb_w : ~fa_w});
    // one bit later the window must still be shut, even with a long sync still high
    @(posedge bclk);
    chk("still released", 10'h0, {8'h0, da_oe, db_oe});
  endtask : frame
  task automatic wrap_up();
    $display("tests %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up
  // ****
  // scenarios
  // ****
  task automatic t_nondelayed();
    frame(1'b0, 7'h05, 1'b0, 8'ha5, 1);
    $display("test nondelayed done");
  endtask : t_nondelayed
  task automatic t_delayed();
    frame(1'b1, 7'h03, 1'b1, 8'h3c, 1);
    $display("test delayed done");
  endtask : t_delayed
  task automatic t_slot_edges();
    frame(1'b1, 7'h00, 1'b1, 8'h5a, 1);
    frame(1'b1, 7'h7f, 1'b0, 8'h81, 1);
    $display("test slot edges done");
  endtask : t_slot_edges
  // a sync held high across the whole slot must not restart it
  task automatic t_square_sync();
    frame(1'b0, 7'h00, 1'b1, 8'hc3, 16);
    repeat (16) @(posedge bclk);
    chk("no restart", 10'h0, {8'h0, da_oe, db_oe});
    $display("test square sync done");
  endtask : t_square_sync
  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    #1000000;
    error_cnt++;
    wrap_up();
  end
  initial begin
    rstn_i = 1'b0;
    dmode = 1'b0;
    slot = 7'h00;
    psel = 1'b0;
    smp = 8'h00;
    repeat (4) @(negedge clk_sys_i);
    rstn_i = 1'b1;
    repeat (8) @(negedge clk_sys_i);
    chk("idle", 10'h0, {6'h0, da_oe, db_oe, fa_oe, fb_oe});
    t_nondelayed();
    t_delayed();
    t_slot_edges();
    t_square_sync();
    wrap_up();
  end
endmodule : pts_tx_port_tb
